/* logic/raf_pkg.sv */
// package: constants and carriers for the record aligned framer
`default_nettype none
package raf_pkg;
   // ==========================================================
   // constants
   localparam logic [8:0]  RAF_MARKER_LEN = 9'h004;
   localparam logic [15:0] RAF_MRS_MIN    = 16'h0080;
   localparam logic [15:0] RAF_MRS_MAX    = 16'hFD00;
   localparam logic [15:0] RAF_OVERHEAD   = 16'h0010;
   localparam logic [31:0] RAF_CRC_INIT   = 32'hFFFF_FFFF;
   localparam logic [31:0] RAF_CRC_POLY   = 32'h82F6_3B78;
   localparam logic [7:0]  RAF_VER_RST    = 8'h01;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR  = 3'b001,
      ST_DATA = 3'b010,
      ST_PAD  = 3'b011,
      ST_CRC  = 3'b100,
      ST_DROP = 3'b101
   } raf_st_e;

   typedef struct packed {
      logic        full_op;
      logic        marker_en;
      logic        crc_off_local;
      logic        crc_off_peer;
      logic        ooo_en;
      logic [7:0]  version;
      logic [15:0] seg_limit;
   } raf_cfg_s;

   typedef struct packed {
      logic        valid;
      logic        first;
      logic [15:0] len;
      logic [7:0]  data;
   } raf_txu_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       frame_end;
   } raf_txt_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       in_order;
   } raf_rxt_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } raf_rec_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] len;
      logic        crc_ok;
      logic        in_order;
      logic [31:0] seq;
   } raf_done_s;
endpackage : raf_pkg
`default_nettype wire

/* logic/raf_crc32c_byte.sv */
// one-byte CRC32C update, reflected form
`default_nettype none
module raf_crc32c_byte
   import raf_pkg::*;
(
   input  wire logic [31:0] crc_in,
   input  wire logic [7:0]  data,
   output logic [31:0]      crc_out
);
   always_comb begin
      logic [31:0] c;
      c = crc_in;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ data[i]) begin
            c = (c >> 1) ^ RAF_CRC_POLY;
         end else begin
            c = c >> 1;
         end
      end
      crc_out = c;
   end
endmodule : raf_crc32c_byte
`default_nettype wire

/* logic/raf_framer.sv */
// record aligned framer: transmit framing and receive deframing
`default_nettype none
module raf_framer
   import raf_pkg::*;
(
   input  wire logic      CORE_CLK,
   input  wire logic      RSTN,
   input  wire raf_cfg_s  CFG,
   input  wire raf_txu_s  TXU,
   output logic           TXU_READY,
   output raf_txt_s       TXT,
   input  wire logic      TXT_READY,
   output logic           TX_REFUSED,
   input  wire raf_rxt_s  RXT,
   input  wire logic      GAP_FILLED,
   input  wire logic      FIN_SEEN,
   output raf_rec_s       RXU,
   output raf_done_s      RXU_DONE,
   output logic           RXU_DELIVERED,
   output logic           RXU_GAP_FILLED,
   output logic           CONN_CLOSING,
   output logic [15:0]    MAX_RECORD_SIZE,
   output logic [7:0]     VERSION
);
   // ==========================================================
   // mode latch at entry to full operation
   logic full_op_ff, mk_on_ff, crc_on_ff, ooo_ff;
   logic entry;
   assign entry = CFG.full_op & ~full_op_ff;

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         full_op_ff <= 1'b0;
         mk_on_ff   <= 1'b0;
         crc_on_ff  <= 1'b1;
         ooo_ff     <= 1'b0;
         VERSION    <= RAF_VER_RST;
      end else begin
         full_op_ff <= CFG.full_op;
         if (entry) begin
            mk_on_ff  <= CFG.marker_en;
            crc_on_ff <= ~(CFG.crc_off_local & CFG.crc_off_peer);
            ooo_ff    <= CFG.ooo_en;
            VERSION   <= CFG.version;
         end
      end
   end

   // ==========================================================
   // max record size: segment limit less framing, clamped
   logic [16:0] mrs_raw;
   assign mrs_raw = {1'b0, CFG.seg_limit} - {1'b0, RAF_OVERHEAD};

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         MAX_RECORD_SIZE <= RAF_MRS_MIN;
      end else if (mrs_raw[16] || mrs_raw[15:0] < RAF_MRS_MIN) begin
         MAX_RECORD_SIZE <= RAF_MRS_MIN;
      end else if (mrs_raw[15:0] > RAF_MRS_MAX) begin
         MAX_RECORD_SIZE <= RAF_MRS_MAX;
      end else begin
         MAX_RECORD_SIZE <= mrs_raw[15:0];
      end
   end

   // ==========================================================
   // transmit
   raf_st_e     tx_st_ff;
   logic [1:0]  tx_sub_ff, tx_pad_ff;
   logic [15:0] tx_len_ff, tx_cnt_ff, tx_foff_ff, tx_ptr_ff;
   logic [8:0]  tx_pos_ff;
   logic [31:0] tx_crc_ff, tx_crc_nxt, tx_fcs;
   logic        tx_first_ff, tx_mk, tx_frm, tx_adv, tx_need, tx_lead;
   logic [7:0]  tx_byte;

   assign tx_frm  = tx_st_ff inside {ST_HDR, ST_DATA, ST_PAD, ST_CRC};
   assign tx_mk   = mk_on_ff && tx_pos_ff < RAF_MARKER_LEN && tx_frm;
   assign tx_lead = tx_mk && tx_st_ff == ST_HDR && tx_sub_ff == 2'd0;
   assign tx_need = tx_st_ff == ST_DATA && !tx_mk;
   // stalls only on a full output slot or a missing record byte
   assign tx_adv  = tx_frm && (!TXT.valid || TXT_READY) && (!tx_need || TXU.valid);
   assign tx_fcs  = crc_on_ff ? ~tx_crc_ff : 32'h0000_0000;
   // ready is combinational so that a byte is never lost to a stalled slot
   assign TXU_READY = (tx_need && tx_adv) || tx_st_ff == ST_DROP;

   always_comb begin
      tx_byte = 8'h00;
      if (tx_mk) begin
         case (tx_pos_ff[1:0])
            2'd2:    tx_byte = tx_ptr_ff[15:8];
            2'd3:    tx_byte = tx_ptr_ff[7:0];
            default: tx_byte = 8'h00;
         endcase
      end else begin
         case (tx_st_ff)
            ST_HDR:  tx_byte = tx_sub_ff[0] ? tx_len_ff[7:0] : tx_len_ff[15:8];
            ST_DATA: tx_byte = TXU.data;
            ST_CRC: begin
               case (tx_sub_ff)
                  2'd0:    tx_byte = tx_fcs[31:24];
                  2'd1:    tx_byte = tx_fcs[23:16];
                  2'd2:    tx_byte = tx_fcs[15:8];
                  default: tx_byte = tx_fcs[7:0];
               endcase
            end
            default: tx_byte = 8'h00;
         endcase
      end
   end

   raf_crc32c_byte u_tx_crc (
      .crc_in  (tx_first_ff ? RAF_CRC_INIT : tx_crc_ff),
      .data    (tx_byte),
      .crc_out (tx_crc_nxt)
   );

   // state, one record per unit in fixed field order
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         tx_st_ff   <= ST_IDLE;
         tx_sub_ff  <= 2'd0;
         tx_pad_ff  <= 2'd0;
         tx_len_ff  <= 16'h0000;
         tx_cnt_ff  <= 16'h0000;
         TX_REFUSED <= 1'b0;
      end else begin
         TX_REFUSED <= 1'b0;
         if (!full_op_ff) begin
            tx_st_ff <= ST_IDLE;
         end else begin
            case (tx_st_ff)
               ST_IDLE: begin
                  if (TXU.valid && TXU.first) begin
                     if (TXU.len == 16'h0000 || TXU.len > MAX_RECORD_SIZE) begin
                        TX_REFUSED <= 1'b1;
                        tx_cnt_ff  <= (TXU.len == 16'h0000) ? 16'h0001 : TXU.len;
                        tx_st_ff   <= ST_DROP;
                     end else begin
                        tx_len_ff <= TXU.len;
                        tx_cnt_ff <= TXU.len;
                        tx_pad_ff <= 2'd2 - TXU.len[1:0];
                        tx_sub_ff <= 2'd0;
                        tx_st_ff  <= ST_HDR;
                     end
                  end
               end
               ST_DROP: begin
                  if (TXU.valid) begin
                     tx_cnt_ff <= tx_cnt_ff - 16'h0001;
                     if (tx_cnt_ff == 16'h0001) begin
                        tx_st_ff <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  if (tx_adv && !tx_mk) begin
                     case (tx_st_ff)
                        ST_HDR: begin
                           tx_sub_ff <= tx_sub_ff + 2'd1;
                           if (tx_sub_ff[0]) begin
                              tx_sub_ff <= 2'd0;
                              tx_st_ff  <= ST_DATA;
                           end
                        end
                        ST_DATA: begin
                           tx_cnt_ff <= tx_cnt_ff - 16'h0001;
                           if (tx_cnt_ff == 16'h0001) begin
                              tx_st_ff <= (tx_pad_ff == 2'd0) ? ST_CRC : ST_PAD;
                           end
                        end
                        ST_PAD: begin
                           tx_pad_ff <= tx_pad_ff - 2'd1;
                           if (tx_pad_ff == 2'd1) begin
                              tx_st_ff <= ST_CRC;
                           end
                        end
                        default: begin
                           tx_sub_ff <= tx_sub_ff + 2'd1;
                           if (tx_sub_ff == 2'd3) begin
                              tx_st_ff <= ST_IDLE;
                           end
                        end
                     endcase
                  end
               end
            endcase
         end
      end
   end

   // stream position, unit offset, back-pointer and CRC
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         tx_pos_ff   <= 9'h000;
         tx_foff_ff  <= 16'h0000;
         tx_ptr_ff   <= 16'h0000;
         tx_crc_ff   <= RAF_CRC_INIT;
         tx_first_ff <= 1'b1;
      end else if (entry) begin
         tx_pos_ff <= 9'h000;
      end else if (tx_st_ff == ST_IDLE) begin
         tx_foff_ff  <= 16'h0000;
         tx_first_ff <= 1'b1;
      end else if (tx_adv) begin
         tx_pos_ff   <= tx_pos_ff + 9'h001;
         tx_first_ff <= 1'b0;
         if (!tx_lead) begin
            tx_foff_ff <= tx_foff_ff + 16'h0001;
         end
         if (tx_mk && tx_pos_ff == 9'h000) begin
            tx_ptr_ff <= tx_foff_ff;
         end
         // field bytes stay out; a marker just ahead of the field is still covered
         if (tx_mk || tx_st_ff != ST_CRC) begin
            tx_crc_ff <= tx_crc_nxt;
         end
      end
   end

   // output slot
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         TXT <= '0;
      end else if (tx_adv) begin
         TXT.valid     <= 1'b1;
         TXT.data      <= tx_byte;
         TXT.frame_end <= !tx_mk && tx_st_ff == ST_CRC && tx_sub_ff == 2'd3;
      end else if (TXT_READY) begin
         TXT.valid <= 1'b0;
      end
   end

   // ==========================================================
   // receive
   raf_st_e     rx_st_ff;
   logic [1:0]  rx_sub_ff, rx_pad_ff;
   logic [15:0] rx_len_ff, rx_cnt_ff;
   logic [8:0]  rx_pos_ff;
   logic [31:0] rx_crc_ff, rx_crc_nxt, rx_fcs_ff, rx_seq_ff, rx_start_ff;
   logic        rx_first_ff, rx_mk, rx_end;

   assign rx_mk  = mk_on_ff && rx_pos_ff < RAF_MARKER_LEN;
   assign rx_end = RXT.valid && !rx_mk && rx_st_ff == ST_CRC && rx_sub_ff == 2'd3;

   raf_crc32c_byte u_rx_crc (
      .crc_in  (rx_first_ff ? RAF_CRC_INIT : rx_crc_ff),
      .data    (RXT.data),
      .crc_out (rx_crc_nxt)
   );

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rx_st_ff    <= ST_IDLE;
         rx_sub_ff   <= 2'd0;
         rx_pad_ff   <= 2'd0;
         rx_len_ff   <= 16'h0000;
         rx_cnt_ff   <= 16'h0000;
         rx_pos_ff   <= 9'h000;
         rx_crc_ff   <= RAF_CRC_INIT;
         rx_fcs_ff   <= 32'h0000_0000;
         rx_seq_ff   <= 32'h0000_0000;
         rx_start_ff <= 32'h0000_0000;
         rx_first_ff <= 1'b1;
         RXU         <= '0;
      end else begin
         RXU.valid <= 1'b0;
         if (!full_op_ff) begin
            rx_st_ff    <= ST_IDLE;
            rx_pos_ff   <= 9'h000;
            rx_first_ff <= 1'b1;
         end else if (rx_st_ff == ST_IDLE) begin
            rx_st_ff  <= ST_HDR;
            rx_sub_ff <= 2'd0;
         end else if (RXT.valid) begin
            rx_pos_ff   <= rx_pos_ff + 9'h001;
            rx_seq_ff   <= rx_seq_ff + 32'h0000_0001;
            rx_first_ff <= 1'b0;
            if (rx_first_ff) begin
               rx_start_ff <= rx_seq_ff;
            end
            if (rx_mk || rx_st_ff != ST_CRC) begin
               rx_crc_ff <= rx_crc_nxt;
            end
            if (!rx_mk) begin
               case (rx_st_ff)
                  ST_HDR: begin
                     if (!rx_sub_ff[0]) begin
                        rx_len_ff[15:8] <= RXT.data;
                        rx_sub_ff       <= 2'd1;
                     end else begin
                        rx_len_ff[7:0] <= RXT.data;
                        rx_cnt_ff      <= {rx_len_ff[15:8], RXT.data};
                        rx_pad_ff      <= 2'd2 - RXT.data[1:0];
                        rx_sub_ff      <= 2'd0;
                        rx_st_ff       <= ({rx_len_ff[15:8], RXT.data} == 16'h0000) ? ST_PAD : ST_DATA;
                     end
                  end
                  ST_DATA: begin
                     RXU.valid <= 1'b1;
                     RXU.data  <= RXT.data;
                     rx_cnt_ff <= rx_cnt_ff - 16'h0001;
                     if (rx_cnt_ff == 16'h0001) begin
                        rx_st_ff <= (rx_pad_ff == 2'd0) ? ST_CRC : ST_PAD;
                     end
                  end
                  ST_PAD: begin
                     rx_pad_ff <= rx_pad_ff - 2'd1;
                     if (rx_pad_ff == 2'd1) begin
                        rx_st_ff <= ST_CRC;
                     end
                  end
                  default: begin
                     rx_fcs_ff <= {rx_fcs_ff[23:0], RXT.data};
                     rx_sub_ff <= rx_sub_ff + 2'd1;
                     if (rx_sub_ff == 2'd3) begin
                        rx_st_ff    <= ST_HDR;
                        rx_first_ff <= 1'b1;
                     end
                  end
               endcase
            end
         end
      end
   end

   // completion, delivery and connection events
   logic rx_ok;
   assign rx_ok = !crc_on_ff || ({rx_fcs_ff[23:0], RXT.data} == ~rx_crc_ff);

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         RXU_DONE       <= '0;
         RXU_DELIVERED  <= 1'b0;
         RXU_GAP_FILLED <= 1'b0;
         CONN_CLOSING   <= 1'b0;
      end else begin
         RXU_DONE.valid <= rx_end;
         if (rx_end) begin
            RXU_DONE.len      <= rx_len_ff;
            RXU_DONE.crc_ok   <= rx_ok;
            RXU_DONE.in_order <= !ooo_ff || RXT.in_order;
            RXU_DONE.seq      <= rx_start_ff;
         end
         RXU_DELIVERED  <= rx_end && rx_ok && (!ooo_ff || RXT.in_order);
         RXU_GAP_FILLED <= ooo_ff && GAP_FILLED;
         if (!full_op_ff) begin
            CONN_CLOSING <= 1'b0;
         end else if (FIN_SEEN) begin
            CONN_CLOSING <= 1'b1;
         end
      end
   end

   // ==========================================================
   // checks
   property p_hdr_first;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (tx_adv && !tx_mk && tx_st_ff == ST_HDR && tx_sub_ff == 2'd0) |=> TXT.data == tx_len_ff[15:8];
   endproperty
   a_hdr_first: assert property (p_hdr_first) else $error("header high octet wrong");
   property p_pad_zero;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (tx_adv && !tx_mk && tx_st_ff == ST_PAD) |=> TXT.valid && TXT.data == 8'h00;
   endproperty
   a_pad_zero: assert property (p_pad_zero) else $error("pad octet not zero");
   property p_mult4;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (tx_adv && !tx_mk && tx_st_ff == ST_CRC && tx_sub_ff == 2'd3) |-> tx_foff_ff[1:0] == 2'd3;
   endproperty
   a_mult4: assert property (p_mult4) else $error("unit not a four-octet multiple");
   property p_mrs;
      @(posedge CORE_CLK) disable iff (!RSTN)
      MAX_RECORD_SIZE >= RAF_MRS_MIN && MAX_RECORD_SIZE <= RAF_MRS_MAX;
   endproperty
   a_mrs: assert property (p_mrs) else $error("max record size out of range");
   property p_refuse;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (full_op_ff && tx_st_ff == ST_IDLE && TXU.valid && TXU.first && TXU.len > MAX_RECORD_SIZE)
         |=> TX_REFUSED ##1 !TX_REFUSED;
   endproperty
   a_refuse: assert property (p_refuse) else $error("oversize record not refused");
   property p_ptr_zero;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (tx_adv && tx_lead && tx_pos_ff == 9'h000) |=> tx_ptr_ff == 16'h0000;
   endproperty
   a_ptr_zero: assert property (p_ptr_zero) else $error("leading marker pointer not zero");
   property p_crc_off;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (RXU_DONE.valid && !crc_on_ff) |-> RXU_DONE.crc_ok;
   endproperty
   a_crc_off: assert property (p_crc_off) else $error("check done with CRC off");
   property p_done_len;
      @(posedge CORE_CLK) disable iff (!RSTN)
      rx_end |=> RXU_DONE.valid && RXU_DONE.len == $past(rx_len_ff);
   endproperty
   a_done_len: assert property (p_done_len) else $error("record length not reported");
   property p_crc_keep;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (entry && !CFG.crc_off_peer) |=> crc_on_ff ##1 crc_on_ff;
   endproperty
   a_crc_keep: assert property (p_crc_keep) else $error("CRC dropped while peer needs it");
   property p_idle_out;
      @(posedge CORE_CLK) disable iff (!RSTN)
      !full_op_ff |=> tx_st_ff == ST_IDLE && rx_st_ff == ST_IDLE;
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("framing outside full operation");
   property p_version;
      @(posedge CORE_CLK) disable iff (!RSTN)
      entry |=> VERSION == $past(CFG.version);
   endproperty
   a_version: assert property (p_version) else $error("version not presented");

   c_unit_sent: cover property (@(posedge CORE_CLK) disable iff (!RSTN) TXT.valid && TXT.frame_end);
   c_marker_in: cover property (@(posedge CORE_CLK) disable iff (!RSTN) tx_adv && tx_mk && tx_ptr_ff != 16'h0000);
   c_rx_good:   cover property (@(posedge CORE_CLK) disable iff (!RSTN) RXU_DONE.valid && RXU_DONE.crc_ok);
   c_refused:   cover property (@(posedge CORE_CLK) disable iff (!RSTN) TX_REFUSED);
endmodule : raf_framer
`default_nettype wire

/* tb/raf_tcp_model.sv */
// tcp stream engine model: loops every sent octet back into the receive side
`default_nettype none
module raf_tcp_model
   import raf_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rstn,
   input  wire logic     slow,
   input  wire logic     corrupt,
   input  wire raf_txt_s txt,
   output logic          txt_ready,
   output raf_rxt_s      rxt
);
   logic [1:0] tick_ff;
   // ==========
   // back-pressure: slow mode takes one octet in four
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_ff   <= 2'h0;
         txt_ready <= 1'b0;
      end else begin
         tick_ff   <= tick_ff + 2'h1;
         txt_ready <= !slow || (tick_ff == 2'h3);
      end
   end
   // ==========
   // loopback: idle cycles invert the data so a stale octet never looks fresh
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxt <= '0;
      end else if (txt.valid && txt_ready) begin
         rxt <= '{1'b1, txt.data ^ {7'h00, corrupt & txt.frame_end}, 1'b1};
      end else begin
         rxt <= '{1'b0, ~rxt.data, 1'b0};
      end
   end
endmodule : raf_tcp_model
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the record aligned framer over a looped tcp model
`default_nettype none
module tb
   import raf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rstn, slow, corrupt, gap, fin, txu_ready, txt_ready, refused, deliv, rx_gap, closing;
   raf_cfg_s    cfg;
   raf_txu_s    txu;
   raf_txt_s    txt;
   raf_rxt_s    rxt;
   raf_rec_s    rxu;
   raf_done_s   done;
   logic [15:0] max_size;
   logic [7:0]  version;
   logic [31:0] crc_e;
   logic        mk_en;
   integer      seed, bad_count, cmp_count, ref_cnt, dlv_cnt, gap_cnt, seq_exp, m, i, spos, uoff;
   logic [8:0]  wire_q[$], exp_q[$];
   logic [7:0]  rx_q[$], rec_q[$];
   logic [15:0] lims[5] = '{16'h0008, 16'h0010, 16'h0090, 16'h0200, 16'hFFFF};
   logic [15:0] lens[8] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h01F0, 16'h01F1, 16'h0000};

   raf_framer raf_framer_i (.CORE_CLK(clk), .RSTN(rstn), .CFG(cfg), .TXU(txu), .TXU_READY(txu_ready), .TXT(txt),
      .TXT_READY(txt_ready), .TX_REFUSED(refused), .RXT(rxt), .GAP_FILLED(gap), .FIN_SEEN(fin), .RXU(rxu),
      .RXU_DONE(done), .RXU_DELIVERED(deliv), .RXU_GAP_FILLED(rx_gap), .CONN_CLOSING(closing),
      .MAX_RECORD_SIZE(max_size), .VERSION(version));
   raf_tcp_model raf_tcp_model_i (.clk(clk), .rstn(rstn), .slow(slow), .corrupt(corrupt), .txt(txt),
      .txt_ready(txt_ready), .rxt(rxt));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ==========
   // monitors
   always @(posedge clk) begin
      if (txt.valid === 1'b1 && txt_ready === 1'b1) wire_q.push_back({txt.frame_end, txt.data});
      if (rxu.valid === 1'b1) rx_q.push_back(rxu.data);
      if (refused === 1'b1) ref_cnt++;
      if (deliv === 1'b1) dlv_cnt++;
      if (rx_gap === 1'b1) gap_cnt++;
   end
   // ==========
   // helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h00_0000, d};
      for (int b = 0; b < 8; b++) r = r[0] ? ((r >> 1) ^ RAF_CRC_POLY) : (r >> 1);
      return r;
   endfunction : crc_step
   function automatic logic [15:0] mrs(input logic [15:0] s);
      logic [15:0] v;
      v = (s < RAF_OVERHEAD) ? 16'h0000 : s - RAF_OVERHEAD;
      return (v < RAF_MRS_MIN) ? RAF_MRS_MIN : (v > RAF_MRS_MAX) ? RAF_MRS_MAX : v;
   endfunction : mrs
   // expected marker when the stream position is due; pointer is the unit offset, zero at a unit start
   task automatic mark;
      logic [7:0] mb;
      if (mk_en && spos % 512 == 0) begin
         for (int q = 0; q < 4; q++) begin
            mb = (q == 2) ? 8'(uoff >> 8) : (q == 3) ? 8'(uoff) : 8'h00;
            exp_q.push_back({1'b0, mb});
            crc_e = crc_step(crc_e, mb);
         end
         spos += 4;
         if (uoff > 0) uoff += 4;
      end
   endtask : mark
   task automatic put(input logic [8:0] b, input logic fcs);
      mark();
      exp_q.push_back(b);
      if (!fcs) crc_e = crc_step(crc_e, b[7:0]);
      spos++;
      uoff++;
   endtask : put
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   // one record out through the framer and back in; expected unit built from scratch
   task automatic send(input logic [15:0] len, input logic crc_on, input logic bad);
      logic [31:0] c;
      logic [7:0]  d;
      logic        refuse;
      integer      n, k, r0, d0;
      refuse = (len == 16'h0000) || (len > mrs(cfg.seg_limit));
      n = (len == 16'h0000) ? 1 : int'(len);
      exp_q = {};
      rec_q = {};
      wire_q = {};
      rx_q = {};
      r0 = ref_cnt;
      d0 = dlv_cnt;
      crc_e = RAF_CRC_INIT;
      uoff = 0;
      for (k = 0; k < 2 + n + (4 - ((n + 2) % 4)) % 4; k++) begin
         d = (k == 0) ? len[15:8] : (k == 1) ? len[7:0] : (k < n + 2) ? 8'($random(seed)) : 8'h00;
         if (k > 1 && k < n + 2) rec_q.push_back(d);
         if (!refuse) put({1'b0, d}, 1'b0);
      end
      if (!refuse) mark();
      c = crc_on ? ~crc_e : 32'h0000_0000;
      for (k = 3; k >= 0 && !refuse; k--) put({k == 0, c[8*k+:8]}, 1'b1);
      @(posedge clk);
      slow <= 1'($random(seed));
      corrupt <= bad;
      txu <= '{1'b1, 1'b1, len, rec_q[0]};
      for (k = 0; k < n; ) begin
         @(negedge clk);
         if (txu_ready === 1'b1) k++;
         @(posedge clk);
         if (k == n) txu <= '0;
         else if (k > 0) txu <= '{1'b1, 1'b0, len, rec_q[k]};
      end
      if (refuse) begin
         repeat (4) @(posedge clk);
         check("refused pulse", ref_cnt, r0 + 1);
         check("refused wire", wire_q.size(), 0);
      end else begin
         for (k = 0; k < 4000 && !(wire_q.size() > 0 && wire_q[wire_q.size()-1][8] === 1'b1); k++) @(posedge clk);
         repeat (4) @(posedge clk);
         check("wire size", wire_q.size(), exp_q.size());
         foreach (exp_q[j]) check("wire octet", wire_q[j], exp_q[j]);
         check("rx size", rx_q.size(), n);
         foreach (rec_q[j]) check("rx octet", rx_q[j], rec_q[j]);
         check("done len", done.len, len);
         check("crc ok", done.crc_ok, !(bad && crc_on));
         check("in order", done.in_order, 1'b1);
         check("seq", done.seq, seq_exp);
         check("delivered", dlv_cnt, d0 + !(bad && crc_on));
         seq_exp += exp_q.size();
      end
      corrupt <= 1'b0;
      $display("unit len %0d done", len);
   endtask : send
   // ==========
   // main sequence
   initial begin
      seed = 65751;
      {bad_count, cmp_count, ref_cnt, dlv_cnt, gap_cnt, seq_exp} = '0;
      {rstn, slow, corrupt, gap, fin} = '0;
      cfg = '0;
      cfg.version = 8'h5A;
      txu = '0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      check("version reset", version, RAF_VER_RST);
      txu <= '{1'b1, 1'b1, 16'h0004, 8'h11};
      repeat (8) @(posedge clk);
      check("no unit before full op", wire_q.size(), 0);
      txu <= '0;
      foreach (lims[j]) begin
         cfg.seg_limit <= lims[j];
         repeat (2) @(posedge clk);
         check("max size", max_size, mrs(lims[j]));
      end
      cfg.seg_limit <= 16'h0200;
      for (m = 0; m < 3; m++) begin
         mk_en = (m == 2);
         spos = 0;
         cfg.marker_en <= mk_en;
         cfg.ooo_en <= mk_en;
         cfg.crc_off_local <= m[0];
         cfg.crc_off_peer <= m[0];
         cfg.version <= m[0] ? 8'h3C : 8'h5A;
         @(posedge clk);
         cfg.full_op <= 1'b1;
         repeat (4) @(posedge clk);
         check("version", version, m[0] ? 8'h3C : 8'h5A);
         foreach (lens[j]) send(lens[j], !m[0], 1'b0);
         for (i = 0; i < 6; i++) send(16'(1 + $unsigned($random(seed)) % 60), !m[0], 1'b0);
         send(16'h0007, !m[0], 1'b1);
         fin <= 1'b1;
         @(posedge clk);
         fin <= 1'b0;
         gap <= 1'b1;
         @(posedge clk);
         gap <= 1'b0;
         repeat (2) @(posedge clk);
         check("closing", closing, 1'b1);
         check("gap filled", gap_cnt, m == 2);
         cfg.full_op <= 1'b0;
         repeat (3) @(posedge clk);
         check("closing cleared", closing, 1'b0);
      end
      test_done();
   end
   initial begin
      #(8 * 90000);
      bad_count++;
      test_done();
   end
endmodule : tb
`default_nettype wire
